//--- core/ptdma_defs.vh
// register offsets, field positions and reset values of the peripheral-triggered dma channel
`ifndef PTDMA_DEFS_VH
`define PTDMA_DEFS_VH

`define PTDMA_AW               24
`define PTDMA_CH0_SRC          24'hfffc00
`define PTDMA_CH0_DST          24'hfffc04
`define PTDMA_CH0_CNT          24'hfffc0c
`define PTDMA_CH0_MODE         24'hfffc14
`define PTDMA_CH0_ADRC         24'hfffc18
`define PTDMA_CH1_SRC          24'hfffc20
`define PTDMA_CH1_DST          24'hfffc24
`define PTDMA_CH1_CNT          24'hfffc2c
`define PTDMA_CH1_MODE         24'hfffc34
`define PTDMA_CH1_ADRC         24'hfffc38
`define PTDMA_CH0_RSEL         24'hfffd20
`define PTDMA_CH1_RSEL         24'hfffd21
`define PTDMA_SER_CTRL         24'hffff82
`define PTDMA_SER_TXD          24'hffff83
`define PTDMA_SER_FLAGS        24'hffff84
`define PTDMA_SER_RXD          24'hffff85

// the serial data registers as seen by the channel's own address generator
`define PTDMA_TXD_ADDR         32'h00ffff83
`define PTDMA_RXD_ADDR         32'h00ffff85

// channel mode control fields
`define PTDMA_MC_ENABLE        31
`define PTDMA_MC_NRD           26
`define PTDMA_MC_ESC_FLAG      17
`define PTDMA_MC_END_FLAG      16
`define PTDMA_MC_SIZE_HI       15
`define PTDMA_MC_SIZE_LO       14
`define PTDMA_MC_MODE_HI       13
`define PTDMA_MC_MODE_LO       12
`define PTDMA_MC_ESC_IE        9
`define PTDMA_MC_END_IE        8
`define PTDMA_MC_FACT_HI       7
`define PTDMA_MC_FACT_LO       6
`define PTDMA_MC_ACK           5
`define PTDMA_MC_RW_MASK       32'h8400f3e0
`define PTDMA_MC_FLAG_MASK     32'h00030000

// address control fields
`define PTDMA_AC_SINGLE        31
`define PTDMA_AC_SRC_HI        21
`define PTDMA_AC_SRC_LO        20
`define PTDMA_AC_DST_HI        17
`define PTDMA_AC_DST_LO        16
`define PTDMA_AC_RW_MASK       32'h80330000

// field codes
`define PTDMA_SIZE_BYTE        2'h0
`define PTDMA_MODE_NORMAL      2'h0
`define PTDMA_FACT_PERIPH      2'h2
`define PTDMA_STEP_FIXED       2'h0
`define PTDMA_STEP_INC         2'h2
`define PTDMA_SEL_TX_EMPTY     8'h92
`define PTDMA_SEL_RX_FULL      8'h91

// serial control and flag bits
`define PTDMA_SC_TIE           7
`define PTDMA_SC_RIE           6
`define PTDMA_SC_TE            5
`define PTDMA_SC_RE            4
`define PTDMA_SF_TX_EMPTY      7
`define PTDMA_SF_RX_FULL       6
`define PTDMA_SF_OVERRUN       5

// reset values
`define PTDMA_RST_WORD         32'h00000000
`define PTDMA_RST_BYTE         8'h00
`define PTDMA_RST_TX_EMPTY     1'b1

`endif

//--- core/ptdma_channel.v
// two peripheral-triggered dma channels with the serial data registers they serve
`timescale 1ns/100ps
`default_nettype none
`include "ptdma_defs.vh"

module ptdma_channel (
	input  wire        clock,
	input  wire        rst_b,
	input  wire [23:0] reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg  [31:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         mem_rd,
	output reg         mem_wr,
	input  wire [7:0]  mem_rdata,
	input  wire        rx_done,
	input  wire [7:0]  rx_byte,
	input  wire        tx_taken,
	output reg  [7:0]  tx_data,
	output reg         transmit_empty_flag,
	output reg  [7:0]  serial_control,
	output reg  [1:0]  end_irq,
	output reg  [1:0]  escape_irq
);

	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_READ  = 3'h1;
	localparam [2:0] S_WAIT  = 3'h2;
	localparam [2:0] S_WRITE = 3'h3;
	localparam [2:0] S_GAP   = 3'h4;

	reg  [31:0] src_reg [0:1];
	reg  [31:0] dst_reg [0:1];
	reg  [31:0] cnt_reg [0:1];
	reg  [31:0] mode_reg [0:1];
	reg  [31:0] adrc_reg [0:1];
	reg  [7:0]  rsel_reg [0:1];
	reg  [2:0]  state_reg;
	reg         ch_reg;
	reg  [7:0]  data_reg;
	reg  [7:0]  rx_hold_reg;
	reg         rx_full_reg;
	reg         overrun_reg;
	reg         rx_full_seen_reg;
	reg         overrun_seen_reg;
	reg         tx_empty_seen_reg;
	wire        rx_request;
	wire        tx_request;
	wire        go0;
	wire        go1;
	wire        mode_sel;
	integer     i;

	// a select value other than the two serial requests never activates the channel
	function req_of;
		input [7:0] sel;
		input       tx_req;
		input       rx_req;
		begin
			req_of = ((sel == `PTDMA_SEL_TX_EMPTY) & tx_req) |
				((sel == `PTDMA_SEL_RX_FULL) & rx_req);
		end
	endfunction

	function [31:0] step_addr;
		input [31:0] addr;
		input [1:0]  mode;
		begin
			if (mode == `PTDMA_STEP_INC) begin
				step_addr = addr + 32'h1;
			end else begin
				step_addr = addr;
			end
		end
	endfunction

	// only byte size, normal mode and peripheral activation are carried out
	function can_start;
		input [31:0] mode;
		input [31:0] cnt;
		input        req;
		begin
			can_start = mode[`PTDMA_MC_ENABLE] &
				(mode[`PTDMA_MC_SIZE_HI:`PTDMA_MC_SIZE_LO] == `PTDMA_SIZE_BYTE) &
				(mode[`PTDMA_MC_MODE_HI:`PTDMA_MC_MODE_LO] == `PTDMA_MODE_NORMAL) &
				(mode[`PTDMA_MC_FACT_HI:`PTDMA_MC_FACT_LO] == `PTDMA_FACT_PERIPH) &
				(cnt != 32'h0) & req;
		end
	endfunction

	// picks which channel's mode register a software write lands in
	assign mode_sel = (reg_addr == `PTDMA_CH1_MODE);
	assign tx_request = serial_control[`PTDMA_SC_TIE] & transmit_empty_flag;
	assign rx_request = serial_control[`PTDMA_SC_RIE] & rx_full_reg;
	assign go0 = can_start(mode_reg[0], cnt_reg[0], req_of(rsel_reg[0], tx_request, rx_request));
	assign go1 = can_start(mode_reg[1], cnt_reg[1], req_of(rsel_reg[1], tx_request, rx_request));

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 2; i = i + 1) begin
				src_reg[i]  <= `PTDMA_RST_WORD;
				dst_reg[i]  <= `PTDMA_RST_WORD;
				cnt_reg[i]  <= `PTDMA_RST_WORD;
				mode_reg[i] <= `PTDMA_RST_WORD;
				adrc_reg[i] <= `PTDMA_RST_WORD;
				rsel_reg[i] <= `PTDMA_RST_BYTE;
			end
			state_reg           <= S_IDLE;
			ch_reg              <= 1'b0;
			data_reg            <= `PTDMA_RST_BYTE;
			rx_hold_reg         <= `PTDMA_RST_BYTE;
			rx_full_reg         <= 1'b0;
			overrun_reg         <= 1'b0;
			rx_full_seen_reg    <= 1'b0;
			overrun_seen_reg    <= 1'b0;
			tx_empty_seen_reg   <= 1'b0;
			transmit_empty_flag <= `PTDMA_RST_TX_EMPTY;
			tx_data             <= `PTDMA_RST_BYTE;
			serial_control      <= `PTDMA_RST_BYTE;
			reg_rdata           <= `PTDMA_RST_WORD;
			mem_addr            <= `PTDMA_RST_WORD;
			mem_wdata           <= `PTDMA_RST_BYTE;
			mem_rd              <= 1'b0;
			mem_wr              <= 1'b0;
			end_irq             <= 2'h0;
			escape_irq          <= 2'h0;
		end else begin
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			reg_rdata <= `PTDMA_RST_WORD;

			// software read: data stands in the next cycle only
			if (reg_rd) begin
				case (reg_addr)
				`PTDMA_CH0_SRC:   reg_rdata <= src_reg[0];
				`PTDMA_CH0_DST:   reg_rdata <= dst_reg[0];
				`PTDMA_CH0_CNT:   reg_rdata <= cnt_reg[0];
				`PTDMA_CH0_MODE:  reg_rdata <= mode_reg[0];
				`PTDMA_CH0_ADRC:  reg_rdata <= adrc_reg[0];
				`PTDMA_CH1_SRC:   reg_rdata <= src_reg[1];
				`PTDMA_CH1_DST:   reg_rdata <= dst_reg[1];
				`PTDMA_CH1_CNT:   reg_rdata <= cnt_reg[1];
				`PTDMA_CH1_MODE:  reg_rdata <= mode_reg[1];
				`PTDMA_CH1_ADRC:  reg_rdata <= adrc_reg[1];
				`PTDMA_CH0_RSEL:  reg_rdata <= {24'h0, rsel_reg[0]};
				`PTDMA_CH1_RSEL:  reg_rdata <= {24'h0, rsel_reg[1]};
				`PTDMA_SER_CTRL:  reg_rdata <= {24'h0, serial_control};
				`PTDMA_SER_TXD:   reg_rdata <= {24'h0, tx_data};
				`PTDMA_SER_RXD:   reg_rdata <= {24'h0, rx_hold_reg};
				`PTDMA_SER_FLAGS: begin
					reg_rdata <= {24'h0, transmit_empty_flag, rx_full_reg, overrun_reg, 5'h0};
					// a flag read as one may afterwards be cleared by writing zero
					if (transmit_empty_flag)
						tx_empty_seen_reg <= 1'b1;
					if (rx_full_reg)
						rx_full_seen_reg <= 1'b1;
					if (overrun_reg)
						overrun_seen_reg <= 1'b1;
				end
				default: reg_rdata <= `PTDMA_RST_WORD;
				endcase
			end

			// software write; the engine below overrides it in the same cycle
			if (reg_wr) begin
				case (reg_addr)
				`PTDMA_CH0_SRC:  src_reg[0] <= reg_wdata;
				`PTDMA_CH0_DST:  dst_reg[0] <= reg_wdata;
				`PTDMA_CH0_CNT:  cnt_reg[0] <= reg_wdata;
				`PTDMA_CH1_SRC:  src_reg[1] <= reg_wdata;
				`PTDMA_CH1_DST:  dst_reg[1] <= reg_wdata;
				`PTDMA_CH1_CNT:  cnt_reg[1] <= reg_wdata;
				`PTDMA_CH0_MODE, `PTDMA_CH1_MODE: begin
					mode_reg[mode_sel] <= (reg_wdata & `PTDMA_MC_RW_MASK) |
						(mode_reg[mode_sel] & reg_wdata & `PTDMA_MC_FLAG_MASK);
					// stopping a live channel before its count ran out is an escape end
					if (mode_reg[mode_sel][`PTDMA_MC_ENABLE] & ~reg_wdata[`PTDMA_MC_ENABLE] &
						(cnt_reg[mode_sel] != 32'h0))
						mode_reg[mode_sel][`PTDMA_MC_ESC_FLAG] <= 1'b1;
				end
				`PTDMA_CH0_ADRC: adrc_reg[0] <= reg_wdata & `PTDMA_AC_RW_MASK;
				`PTDMA_CH1_ADRC: adrc_reg[1] <= reg_wdata & `PTDMA_AC_RW_MASK;
				`PTDMA_CH0_RSEL: rsel_reg[0] <= reg_wdata[7:0];
				`PTDMA_CH1_RSEL: rsel_reg[1] <= reg_wdata[7:0];
				`PTDMA_SER_CTRL: begin
					serial_control <= reg_wdata[7:0];
					if (!reg_wdata[`PTDMA_SC_TE])
						transmit_empty_flag <= 1'b1;
				end
				`PTDMA_SER_TXD:  tx_data <= reg_wdata[7:0];
				`PTDMA_SER_FLAGS: begin
					if (!reg_wdata[`PTDMA_SF_TX_EMPTY] && tx_empty_seen_reg) begin
						transmit_empty_flag <= 1'b0;
						tx_empty_seen_reg   <= 1'b0;
					end
					if (!reg_wdata[`PTDMA_SF_RX_FULL] && rx_full_seen_reg) begin
						rx_full_reg      <= 1'b0;
						rx_full_seen_reg <= 1'b0;
					end
					if (!reg_wdata[`PTDMA_SF_OVERRUN] && overrun_seen_reg) begin
						overrun_reg      <= 1'b0;
						overrun_seen_reg <= 1'b0;
					end
				end
				default: ;
				endcase
			end

			// transfer engine; channel 0 wins when both are requested
			case (state_reg)
			S_IDLE: begin
				if (go0 | go1) begin
					ch_reg    <= ~go0;
					state_reg <= S_READ;
				end
			end
			S_READ: begin
				if (adrc_reg[ch_reg][`PTDMA_AC_SINGLE]) begin
					// single address: the holding register is the implied partner
					data_reg  <= rx_hold_reg;
					state_reg <= S_WRITE;
					if (mode_reg[ch_reg][`PTDMA_MC_ACK]) begin
						rx_full_reg      <= 1'b0;
						rx_full_seen_reg <= 1'b0;
					end
				end else if (src_reg[ch_reg] == `PTDMA_RXD_ADDR) begin
					data_reg  <= rx_hold_reg;
					state_reg <= S_WRITE;
					if (mode_reg[ch_reg][`PTDMA_MC_ACK]) begin
						rx_full_reg      <= 1'b0;
						rx_full_seen_reg <= 1'b0;
					end
				end else begin
					mem_addr  <= src_reg[ch_reg];
					mem_rd    <= 1'b1;
					state_reg <= S_WAIT;
				end
			end
			S_WAIT: begin
				data_reg  <= mem_rdata;
				state_reg <= S_WRITE;
			end
			S_WRITE: begin
				if (dst_reg[ch_reg] == `PTDMA_TXD_ADDR) begin
					tx_data <= data_reg;
					if (mode_reg[ch_reg][`PTDMA_MC_ACK]) begin
						transmit_empty_flag <= 1'b0;
						tx_empty_seen_reg   <= 1'b0;
					end
				end else begin
					mem_addr  <= dst_reg[ch_reg];
					mem_wdata <= data_reg;
					mem_wr    <= 1'b1;
				end
				src_reg[ch_reg] <= step_addr(src_reg[ch_reg],
					adrc_reg[ch_reg][`PTDMA_AC_SRC_HI:`PTDMA_AC_SRC_LO]);
				dst_reg[ch_reg] <= step_addr(dst_reg[ch_reg],
					adrc_reg[ch_reg][`PTDMA_AC_DST_HI:`PTDMA_AC_DST_LO]);
				cnt_reg[ch_reg] <= cnt_reg[ch_reg] - 32'h1;
				if (cnt_reg[ch_reg] == 32'h1) begin
					mode_reg[ch_reg][`PTDMA_MC_ENABLE]   <= 1'b0;
					mode_reg[ch_reg][`PTDMA_MC_END_FLAG] <= 1'b1;
				end
				if (mode_reg[ch_reg][`PTDMA_MC_NRD])
					state_reg <= S_GAP;
				else
					state_reg <= S_IDLE;
			end
			S_GAP: state_reg <= S_IDLE;
			default: state_reg <= S_IDLE;
			endcase

			// reception completes only while the receiver is enabled
			if (rx_done && serial_control[`PTDMA_SC_RE]) begin
				if (rx_full_reg && !(state_reg == S_READ && mode_reg[ch_reg][`PTDMA_MC_ACK] &&
					(adrc_reg[ch_reg][`PTDMA_AC_SINGLE] || src_reg[ch_reg] == `PTDMA_RXD_ADDR))) begin
					overrun_reg <= 1'b1;
				end else begin
					rx_hold_reg <= rx_byte;
					rx_full_reg <= 1'b1;
				end
			end

			// the shifter taking a byte frees the transmit register
			if (tx_taken && serial_control[`PTDMA_SC_TE])
				transmit_empty_flag <= 1'b1;

			for (i = 0; i < 2; i = i + 1) begin
				end_irq[i]    <= mode_reg[i][`PTDMA_MC_END_FLAG] &
					mode_reg[i][`PTDMA_MC_END_IE];
				escape_irq[i] <= mode_reg[i][`PTDMA_MC_ESC_FLAG] &
					mode_reg[i][`PTDMA_MC_ESC_IE];
			end
		end
	end

endmodule
`default_nettype wire

//--- tb/ptdma_channel_assertions.sv
// port-level checks of the dma channel engine and serial flags
`timescale 1ns/100ps
`default_nettype none
module ptdma_channel_checker (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        reg_wr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_rdata,
	input wire logic        tx_taken,
	input wire logic [7:0]  tx_data,
	input wire logic        transmit_empty_flag,
	input wire logic [7:0]  serial_control,
	input wire logic [1:0]  end_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_read_then_write: assert property (mem_rd |-> ##2 (mem_wr || !transmit_empty_flag))
		else $error("read not followed by write");
	a_read_pulse: assert property (mem_rd |=> !mem_rd)
		else $error("memory read longer than one cycle");
	a_write_pulse: assert property (mem_wr |=> !mem_wr)
		else $error("memory write longer than one cycle");
	a_single_access: assert property (!(mem_rd && mem_wr))
		else $error("read and write together");
	a_wdata_copy: assert property (mem_wr && $past(mem_rd, 2) |-> mem_wdata == $past(mem_rdata, 2))
		else $error("written byte differs from read byte");
	a_tx_copy: assert property ($fell(transmit_empty_flag) && $past(mem_rd, 2)
		|-> tx_data == $past(mem_rdata, 2))
		else $error("transmit byte differs from read byte");
	a_tx_clear_cause: assert property ($fell(transmit_empty_flag)
		|-> $past(mem_rd, 2) || $past(reg_wr))
		else $error("transmit flag cleared without cause");
	a_tx_refill: assert property (tx_taken && serial_control[5] |=> transmit_empty_flag)
		else $error("transmit flag not set after shift");
	cover property (mem_rd ##2 mem_wr);
	cover property ($fell(transmit_empty_flag));
	cover property ($rose(end_irq[1]));
endmodule
bind ptdma_channel ptdma_channel_checker u_chk (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr),
	.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
	.tx_taken(tx_taken), .tx_data(tx_data), .transmit_empty_flag(transmit_empty_flag),
	.serial_control(serial_control), .end_irq(end_irq));
`default_nettype wire

//--- tb/ptdma_far_side.sv
// far side model: byte memory and a transmit shifter that drains the holding register
`timescale 1ns/100ps
`default_nettype none
module ptdma_far_side (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [31:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	output var  logic [7:0]  mem_rdata,
	input  wire logic [7:0]  tx_data,
	input  wire logic        transmit_empty_flag,
	input  wire logic        te,
	output var  logic        tx_taken
);
	logic [7:0] mem [0:255];
	logic [7:0] txq [$];
	logic [2:0] dly;
	logic [7:0] junk;
	// read data stand in the cycle the read strobe is high; the engine samples them there
	always @* mem_rdata = mem_rd ? (mem_addr[7:0] ^ 8'h3c) : junk;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			junk <= 8'h00;
			tx_taken <= 1'b0;
			dly <= 3'h0;
		end else begin
			// toggles outside its valid cycle so a late sample never matches by luck
			junk <= ~junk;
			if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
			tx_taken <= 1'b0;
			if (te && !transmit_empty_flag && !tx_taken) dly <= dly + 3'h1;
			// a slow shifter: the holding register stays full for several cycles
			if (dly == 3'h4) begin
				dly <= 3'h0;
				tx_taken <= 1'b1;
				txq.push_back(tx_data);
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/ptdma_channel_tb.sv
// self-checking bench for the peripheral-triggered dma channel
`timescale 1ns/100ps
`default_nettype none
`include "ptdma_defs.vh"
module ptdma_channel_tb;
	logic        clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_done = 1'b0;
	logic        mem_rd, mem_wr, tx_taken, tef;
	logic [23:0] reg_addr = 24'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, v;
	logic [7:0]  rx_byte = 8'h00, mem_wdata, mem_rdata, tx_data, sctl, b [3];
	logic [1:0]  end_irq, escape_irq;
	int          fail_count = 0, checked = 0, i;
	logic [23:0] ra [6] = '{`PTDMA_CH0_SRC, `PTDMA_CH1_CNT, `PTDMA_CH0_MODE, `PTDMA_CH1_ADRC,
		`PTDMA_CH1_RSEL, `PTDMA_SER_CTRL};
	logic [23:0] wa [4] = '{`PTDMA_CH1_SRC, `PTDMA_CH1_DST, `PTDMA_CH1_ADRC, `PTDMA_CH0_RSEL};
	logic [31:0] wm [4] = '{32'hffffffff, 32'hffffffff, `PTDMA_AC_RW_MASK, 32'h000000ff};
	ptdma_channel dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
		.rx_done(rx_done), .rx_byte(rx_byte), .tx_taken(tx_taken), .tx_data(tx_data),
		.transmit_empty_flag(tef), .serial_control(sctl), .end_irq(end_irq),
		.escape_irq(escape_irq));
	ptdma_far_side far (.clock(clock), .rst_b(rst_b), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata), .tx_data(tx_data),
		.transmit_empty_flag(tef), .te(sctl[`PTDMA_SC_TE]), .tx_taken(tx_taken));
	always #2.5 clock = ~clock;
	function automatic logic [31:0] mbyte(input logic [31:0] a);
		return {24'h0, a[7:0] ^ 8'h3c};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [23:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk($sformatf("register %h", a), exp, reg_rdata);
	endtask
	task automatic rx_send(input logic [7:0] d);
		@(posedge clock);
		rx_done <= 1'b1;
		rx_byte <= d;
		@(posedge clock);
		rx_done <= 1'b0;
		rx_byte <= ~d;
		repeat (6) @(posedge clock);
	endtask
	task automatic wait_end(input int ch);
		int n;
		n = 0;
		while (end_irq[ch] !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		chk("end_irq", 32'h1, {31'h0, end_irq[ch]});
	endtask
	task automatic close_out;
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		close_out;
	end
	initial begin
		void'($urandom(32'h40e7cf8b));
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		foreach (ra[k]) rd(ra[k], 32'h0);
		rd(`PTDMA_SER_FLAGS, 32'h80);
		wr(24'hfffc40, 32'hffffffff);
		rd(24'hfffc40, 32'h0);
		$display("reset and unmapped test done");
		for (i = 0; i < 4; i++) begin
			v = $urandom;
			wr(wa[i], v);
			rd(wa[i], v & wm[i]);
		end
		// channel 0 count is still zero, so enabling with every bit set cannot start it
		wr(`PTDMA_CH0_MODE, 32'hffffffff);
		rd(`PTDMA_CH0_MODE, `PTDMA_MC_RW_MASK);
		wr(`PTDMA_CH0_MODE, 32'h0);
		rd(`PTDMA_CH0_MODE, 32'h0);
		$display("register access test done");
		wr(`PTDMA_SER_CTRL, 32'ha0);
		wr(`PTDMA_CH0_SRC, 32'h100);
		wr(`PTDMA_CH0_DST, `PTDMA_TXD_ADDR);
		wr(`PTDMA_CH0_CNT, 32'h4);
		wr(`PTDMA_CH0_ADRC, 32'h00200000);
		wr(`PTDMA_CH0_RSEL, 32'h92);
		wr(`PTDMA_CH0_MODE, 32'h800001a0);
		wait_end(0);
		repeat (10) @(posedge clock);
		chk("sent count", 32'h4, far.txq.size());
		for (i = 0; i < 4; i++) chk("sent byte", mbyte(32'h100 + i), {24'h0, far.txq[i]});
		rd(`PTDMA_CH0_MODE, 32'h000101a0);
		rd(`PTDMA_CH0_SRC, 32'h104);
		rd(`PTDMA_CH0_CNT, 32'h0);
		wr(`PTDMA_CH0_MODE, 32'h000100a0);
		rd(`PTDMA_CH0_MODE, 32'h000100a0);
		chk("end_irq", 32'h0, {30'h0, end_irq});
		wr(`PTDMA_CH0_MODE, 32'h0);
		rd(`PTDMA_CH0_MODE, 32'h0);
		$display("memory to transmit test done");
		wr(`PTDMA_SER_CTRL, 32'h50);
		wr(`PTDMA_CH1_SRC, `PTDMA_RXD_ADDR);
		wr(`PTDMA_CH1_DST, 32'h200);
		wr(`PTDMA_CH1_CNT, 32'h3);
		wr(`PTDMA_CH1_ADRC, 32'h00020000);
		wr(`PTDMA_CH1_RSEL, 32'h91);
		wr(`PTDMA_CH1_MODE, 32'h800001a0);
		for (i = 0; i < 3; i++) begin
			b[i] = 8'($urandom);
			rx_send(b[i]);
		end
		wait_end(1);
		for (i = 0; i < 3; i++) chk("stored byte", {24'h0, b[i]}, {24'h0, far.mem[i]});
		rd(`PTDMA_CH1_DST, 32'h203);
		rd(`PTDMA_SER_FLAGS, 32'h80);
		$display("receive to memory test done");
		b[0] = 8'($urandom);
		rx_send(b[0]);
		rx_send(~b[0]);
		wr(`PTDMA_SER_CTRL, 32'h0);
		rd(`PTDMA_SER_FLAGS, 32'he0);
		rd(`PTDMA_SER_RXD, {24'h0, b[0]});
		wr(`PTDMA_SER_FLAGS, 32'h80);
		rd(`PTDMA_SER_FLAGS, 32'h80);
		$display("overrun test done");
		wr(`PTDMA_CH0_CNT, 32'h5);
		wr(`PTDMA_CH0_MODE, 32'h80000280);
		wr(`PTDMA_CH0_MODE, 32'h00000280);
		rd(`PTDMA_CH0_MODE, 32'h00020280);
		chk("escape_irq", 32'h1, {30'h0, escape_irq});
		wr(`PTDMA_CH0_MODE, 32'h0);
		rd(`PTDMA_CH0_MODE, 32'h0);
		$display("escape test done");
		wr(`PTDMA_SER_CTRL, 32'h80);
		wr(`PTDMA_CH0_SRC, 32'h10);
		wr(`PTDMA_CH0_DST, 32'h40);
		wr(`PTDMA_CH0_CNT, 32'h2);
		wr(`PTDMA_CH0_ADRC, 32'h00220000);
		wr(`PTDMA_CH0_MODE, 32'h800001a0);
		wait_end(0);
		for (i = 0; i < 2; i++) chk("copied byte", mbyte(32'h10 + i), {24'h0, far.mem[64 + i]});
		rd(`PTDMA_CH0_DST, 32'h42);
		$display("memory to memory test done");
		close_out;
	end
endmodule
`default_nettype wire
